/* pkg/ddr_cmd_pkg.sv */
package ddr_cmd_pkg;
    localparam int ADDR_W = 13;
    localparam int BANK_W = 2;
    localparam int MODE_W = 15;
    localparam int COL_W = 9;
    localparam int BEAT_W = 3;
    // Mode register field positions, then the auto-close address bit and the extended-select bank bit
    localparam int BL_LSB = 0;
    localparam int BL_MSB = 2;
    localparam int ORDER_BIT = 3;
    localparam int LAT_LSB = 4;
    localparam int LAT_MSB = 6;
    localparam int TEST_LSB = 7;
    localparam int TEST_MSB = 8;
    localparam int AUTO_CLOSE_BIT = 10;
    localparam int EXT_SEL_BIT = 0;
    // Burst length codes
    localparam logic [2:0] BL_CODE_2 = 3'h1;
    localparam logic [2:0] BL_CODE_4 = 3'h2;
    localparam logic [2:0] BL_CODE_8 = 3'h3;
    // Read latency codes, value in half cycles
    localparam logic [2:0] LAT_CODE_2 = 3'h2;
    localparam logic [2:0] LAT_CODE_3 = 3'h3;
    localparam logic [2:0] LAT_CODE_25 = 3'h6;
    localparam logic [3:0] HALF_LAT_2 = 4'h4;
    localparam logic [3:0] HALF_LAT_3 = 4'h6;
    localparam logic [3:0] HALF_LAT_25 = 4'h5;
    localparam logic [1:0] TEST_NORMAL = 2'h0;
    // Strobe pattern {rowN, colN, wrN} with chip select low
    localparam logic [2:0] PAT_OPEN = 3'h3;
    localparam logic [2:0] PAT_CLOSE = 3'h2;
    localparam logic [2:0] PAT_WRITE = 3'h4;
    localparam logic [2:0] PAT_READ = 3'h5;
    localparam logic [2:0] PAT_NOP = 3'h7;
    localparam logic [2:0] PAT_STOP = 3'h6;
    localparam logic [2:0] PAT_REFRESH = 3'h1;
    localparam logic [2:0] PAT_MODE = 3'h0;
    localparam int MODE_RECOVERY_CYCLES = 2;

    typedef enum logic [3:0] {
        CMD_DESELECT, CMD_NOP, CMD_OPEN, CMD_CLOSE, CMD_CLOSE_ALL,
        CMD_WRITE, CMD_READ, CMD_STOP, CMD_MODE, CMD_EXT_MODE,
        CMD_REFRESH, CMD_SELF_ENTER, CMD_SELF_EXIT, CMD_PD_ENTER,
        CMD_PD_EXIT, CMD_ILLEGAL
    } cmd_t;

    typedef enum logic [2:0] {
        PWR_ON, PWR_SELF, PWR_PD_PRE, PWR_PD_ACT
    } pwr_t;

    function automatic logic [3:0] burstLen(input logic [2:0] code);
        case (code)
            BL_CODE_2: burstLen = 4'h2;
            BL_CODE_4: burstLen = 4'h4;
            BL_CODE_8: burstLen = 4'h8;
            default: burstLen = 4'h0;
        endcase
    endfunction : burstLen
endpackage : ddr_cmd_pkg

/* pkg/ddr_cmd_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface ddr_cmd_if
    import ddr_cmd_pkg::*;
(
    input wire logic clock
);
    logic chipSelectN;
    logic rowStrobeN;
    logic columnStrobeN;
    logic writeStrobeN;
    logic clockGateInput;
    logic [BANK_W-1:0] bankSelect;
    logic [ADDR_W-1:0] address;
    logic lowerLaneMask;
    logic upperLaneMask;

    modport controller (
        input clock,
        output chipSelectN, rowStrobeN, columnStrobeN, writeStrobeN,
        output clockGateInput, bankSelect, address,
        output lowerLaneMask, upperLaneMask
    );
    modport memory (
        input clock,
        input chipSelectN, rowStrobeN, columnStrobeN, writeStrobeN,
        input clockGateInput, bankSelect, address,
        input lowerLaneMask, upperLaneMask
    );
endinterface : ddr_cmd_if
`default_nettype wire

/* rtl/burst_order.sv */
`timescale 1ns/1ps
`default_nettype none
module burst_order
    import ddr_cmd_pkg::*;
(
    input wire logic [COL_W-1:0] startCol,
    input wire logic [BEAT_W-1:0] beat,
    input wire logic [2:0] lenCode,
    input wire logic interleaved,
    output logic [COL_W-1:0] beatCol
);
    logic [BEAT_W-1:0] lowMask;
    logic [BEAT_W-1:0] seqOff;
    logic [BEAT_W-1:0] offset;

    always_comb begin
        case (lenCode)
            BL_CODE_2: lowMask = 3'h1;
            BL_CODE_4: lowMask = 3'h3;
            BL_CODE_8: lowMask = 3'h7;
            default: lowMask = 3'h0;
        endcase
        seqOff = startCol[BEAT_W-1:0] + beat;
        offset = interleaved ? (startCol[BEAT_W-1:0] ^ beat) : seqOff;
        beatCol = {startCol[COL_W-1:BEAT_W],
            (startCol[BEAT_W-1:0] & ~lowMask) | (offset & lowMask)};
    end
endmodule : burst_order
`default_nettype wire

/* rtl/ddr_memory_end.sv */
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module ddr_memory_end
    import ddr_cmd_pkg::*;
(
    input wire logic rst,
    ddr_cmd_if.memory link,
    output logic [3:0] cmdCode,
    output logic cmdValid,
    output logic [3:0] bankOpen,
    output logic [1:0] powerState,
    output logic [MODE_W-1:0] modeReg,
    output logic [MODE_W-1:0] extModeReg,
    output logic modeWritten,
    output logic [3:0] burstLength,
    output logic interleaved,
    output logic [3:0] readLatencyHalf,
    output logic testMode,
    output logic burstActive,
    output logic burstIsWrite,
    output logic autoClose,
    output logic [COL_W-1:0] beatColumn,
    output logic [1:0] laneWriteEnable,
    output logic [1:0] recoveryLeft
);
    logic [BANK_W-1:0] bankIn;
    logic [ADDR_W-1:0] addrIn;
    logic [2:0] pat;
    logic gateNow;
    logic gatePrev_q;
    logic anyOpen;
    logic idleCmd;
    cmd_t cmd;
    pwr_t pwr_q;
    logic [3:0] bankOpen_q;
    logic [MODE_W-1:0] mode_q;
    logic [MODE_W-1:0] extMode_q;
    logic modeWritten_q;
    logic [BANK_W-1:0] burstBank_q;
    logic [COL_W-1:0] startCol_q;
    logic [BEAT_W-1:0] beat_q;
    logic [3:0] beatsLeft_q;
    logic burstWrite_q;
    logic autoClose_q;
    logic [1:0] recovery_q;
    logic [3:0] cmdCode_q;
    logic cmdValid_q;
    logic [1:0] laneEn_q;

    assign bankIn = link.bankSelect;
    assign addrIn = link.address;
    assign gateNow = link.clockGateInput;
    assign pat = {link.rowStrobeN, link.columnStrobeN, link.writeStrobeN};
    assign anyOpen = |bankOpen_q;
    assign idleCmd = link.chipSelectN || (pat == PAT_NOP);

    always_ff @(posedge link.clock) begin
        if (rst) begin
            gatePrev_q <= 1'b1;
        end else begin
            gatePrev_q <= gateNow;
        end
    end

    always_comb begin
        cmd = CMD_ILLEGAL;
        if (pwr_q != PWR_ON) begin
            if (!gatePrev_q && gateNow && idleCmd) begin
                cmd = (pwr_q == PWR_SELF) ? CMD_SELF_EXIT : CMD_PD_EXIT;
            end else begin
                cmd = CMD_DESELECT;
            end
        end else if (gatePrev_q && !gateNow && idleCmd) begin
            cmd = CMD_PD_ENTER;
        end else if (link.chipSelectN) begin
            cmd = CMD_DESELECT;
        end else if (gatePrev_q) begin
            case (pat)
                PAT_OPEN: cmd = CMD_OPEN;
                PAT_CLOSE: cmd = addrIn[AUTO_CLOSE_BIT] ?
                    CMD_CLOSE_ALL : CMD_CLOSE;
                PAT_WRITE: cmd = CMD_WRITE;
                PAT_READ: cmd = CMD_READ;
                PAT_NOP: cmd = CMD_NOP;
                PAT_STOP: cmd = burstActive ? CMD_STOP : CMD_NOP;
                PAT_REFRESH: begin
                    if (!anyOpen) begin
                        cmd = gateNow ? CMD_REFRESH : CMD_SELF_ENTER;
                    end
                end
                PAT_MODE: cmd = bankIn[EXT_SEL_BIT] ?
                    CMD_EXT_MODE : CMD_MODE;
                default: cmd = CMD_ILLEGAL;
            endcase
        end
    end

    always_ff @(posedge link.clock) begin
        if (rst) begin
            cmdCode_q <= 4'h0;
            cmdValid_q <= 1'b0;
        end else begin
            cmdCode_q <= cmd;
            cmdValid_q <= (cmd != CMD_DESELECT) && (cmd != CMD_NOP);
        end
    end

    always_ff @(posedge link.clock) begin
        if (rst) begin
            pwr_q <= PWR_ON;
        end else begin
            case (cmd)
                CMD_SELF_ENTER: pwr_q <= PWR_SELF;
                CMD_PD_ENTER: pwr_q <= anyOpen ? PWR_PD_ACT : PWR_PD_PRE;
                CMD_SELF_EXIT, CMD_PD_EXIT: pwr_q <= PWR_ON;
                default: pwr_q <= pwr_q;
            endcase
        end
    end

    // Bank state; the controller guards bank targets, but not a reopen during an auto-close burst
    always_ff @(posedge link.clock) begin
        if (rst) begin
            bankOpen_q <= 4'h0;
        end else begin
            if (burstActive && autoClose_q && beatsLeft_q == 4'h1) begin
                bankOpen_q[burstBank_q] <= 1'b0;
            end
            if (cmd == CMD_OPEN) begin
                bankOpen_q[bankIn] <= 1'b1;
            end else if (cmd == CMD_CLOSE) begin
                bankOpen_q[bankIn] <= 1'b0;
            end else if (cmd == CMD_CLOSE_ALL) begin
                bankOpen_q <= 4'h0;
            end
        end
    end

    // Mode registers are not reset: contents stay undefined until written
    always_ff @(posedge link.clock) begin
        if (cmd == CMD_MODE) begin
            mode_q <= {bankIn, addrIn};
        end
        if (cmd == CMD_EXT_MODE) begin
            extMode_q <= {bankIn, addrIn};
        end
    end

    always_ff @(posedge link.clock) begin
        if (rst) begin
            modeWritten_q <= 1'b0;
            recovery_q <= 2'h0;
        end else begin
            if (cmd == CMD_MODE) begin
                modeWritten_q <= 1'b1;
            end
            if (cmd == CMD_MODE || cmd == CMD_EXT_MODE) begin
                recovery_q <= 2'(MODE_RECOVERY_CYCLES);
            end else if (recovery_q != 2'h0) begin
                recovery_q <= recovery_q - 2'h1;
            end
        end
    end

    // Burst tracking: a new access restarts, burst stop ends it
    always_ff @(posedge link.clock) begin
        if (rst) begin
            beatsLeft_q <= 4'h0;
            beat_q <= 3'h0;
            startCol_q <= '0;
            burstBank_q <= '0;
            burstWrite_q <= 1'b0;
            autoClose_q <= 1'b0;
        end else if (cmd == CMD_READ || cmd == CMD_WRITE) begin
            beatsLeft_q <= burstLen(mode_q[BL_MSB:BL_LSB]);
            beat_q <= 3'h0;
            startCol_q <= addrIn[COL_W-1:0];
            burstBank_q <= bankIn;
            burstWrite_q <= (cmd == CMD_WRITE);
            autoClose_q <= addrIn[AUTO_CLOSE_BIT];
        end else if (cmd == CMD_STOP) begin
            beatsLeft_q <= 4'h0;
        end else if (burstActive) begin
            beatsLeft_q <= beatsLeft_q - 4'h1;
            beat_q <= beat_q + 3'h1;
        end
    end

    always_ff @(posedge link.clock) begin
        if (rst) begin
            laneEn_q <= 2'h0;
        end else if (burstActive && burstWrite_q) begin
            laneEn_q <= {~link.upperLaneMask, ~link.lowerLaneMask};
        end else begin
            laneEn_q <= 2'h0;
        end
    end

    burst_order orderUnit (
        .startCol(startCol_q),
        .beat(beat_q),
        .lenCode(mode_q[BL_MSB:BL_LSB]),
        .interleaved(mode_q[ORDER_BIT]),
        .beatCol(beatColumn)
    );

    always_comb begin
        case (mode_q[LAT_MSB:LAT_LSB])
            LAT_CODE_2: readLatencyHalf = HALF_LAT_2;
            LAT_CODE_3: readLatencyHalf = HALF_LAT_3;
            LAT_CODE_25: readLatencyHalf = HALF_LAT_25;
            default: readLatencyHalf = 4'h0;
        endcase
    end

    assign burstActive = beatsLeft_q != 4'h0;
    assign burstIsWrite = burstWrite_q;
    assign autoClose = autoClose_q;
    assign cmdCode = cmdCode_q;
    assign cmdValid = cmdValid_q;
    assign bankOpen = bankOpen_q;
    assign powerState = pwr_q[1:0];
    assign modeReg = mode_q;
    assign extModeReg = extMode_q;
    assign modeWritten = modeWritten_q;
    assign burstLength = burstLen(mode_q[BL_MSB:BL_LSB]);
    assign interleaved = mode_q[ORDER_BIT];
    assign testMode = mode_q[TEST_MSB:TEST_LSB] != TEST_NORMAL;
    assign laneWriteEnable = laneEn_q;
    assign recoveryLeft = recovery_q;
endmodule : ddr_memory_end
`default_nettype wire

/* rtl/ddr_controller_end.sv */
`timescale 1ns/1ps
`default_nettype none
module ddr_controller_end
    import ddr_cmd_pkg::*;
(
    input wire logic rst,
    ddr_cmd_if.controller link,
    input wire logic reqValid,
    input wire logic [2:0] reqPattern,
    input wire logic reqChipSelectN,
    input wire logic reqGate,
    input wire logic [BANK_W-1:0] reqBank,
    input wire logic [ADDR_W-1:0] reqAddress,
    input wire logic [1:0] reqMask,
    output logic reqReady,
    output logic [3:0] openBanks
);
    logic [1:0] recovery_q;
    logic [3:0] open_q;
    logic isMode;
    logic isOpen;
    logic isAccess;
    logic legal;

    assign isMode = !reqChipSelectN && reqPattern == PAT_MODE;
    assign isOpen = !reqChipSelectN && reqPattern == PAT_OPEN;
    assign isAccess = !reqChipSelectN &&
        (reqPattern == PAT_READ || reqPattern == PAT_WRITE);
    // Stall anything but idle commands during recovery, bank misuse too
    always_comb begin
        legal = 1'b1;
        if (recovery_q != 2'h0 && !(reqChipSelectN || reqPattern == PAT_NOP)) begin
            legal = 1'b0;
        end
        if (isOpen && open_q[reqBank]) begin
            legal = 1'b0;
        end
        if (isAccess && !open_q[reqBank]) begin
            legal = 1'b0;
        end
        if (isMode && (open_q != 4'h0 || !reqGate)) begin
            legal = 1'b0;
        end
    end
    assign reqReady = legal;

    always_ff @(posedge link.clock) begin
        if (rst) begin
            recovery_q <= 2'h0;
            open_q <= 4'h0;
        end else if (reqValid && legal) begin
            recovery_q <= isMode ? 2'(MODE_RECOVERY_CYCLES) :
                (recovery_q != 2'h0 ? recovery_q - 2'h1 : 2'h0);
            if (isOpen) begin
                open_q[reqBank] <= 1'b1;
            end else if (!reqChipSelectN && reqPattern == PAT_CLOSE) begin
                if (reqAddress[AUTO_CLOSE_BIT]) begin
                    open_q <= 4'h0;
                end else begin
                    open_q[reqBank] <= 1'b0;
                end
            end else if (isAccess && reqAddress[AUTO_CLOSE_BIT]) begin
                // Counted closed at once; a reopen mid-burst is not guarded
                open_q[reqBank] <= 1'b0;
            end
        end else if (recovery_q != 2'h0) begin
            recovery_q <= recovery_q - 2'h1;
        end
    end
    assign openBanks = open_q;

    always_ff @(posedge link.clock) begin
        if (rst) begin
            link.chipSelectN <= 1'b1;
            {link.rowStrobeN, link.columnStrobeN, link.writeStrobeN} <= PAT_NOP;
            link.clockGateInput <= 1'b1;
            link.bankSelect <= '0;
            link.address <= '0;
            {link.upperLaneMask, link.lowerLaneMask} <= 2'h0;
        end else begin
            {link.upperLaneMask, link.lowerLaneMask} <= reqMask;
            link.clockGateInput <= reqValid ? reqGate : link.clockGateInput;
            if (reqValid && legal) begin
                link.chipSelectN <= reqChipSelectN;
                {link.rowStrobeN, link.columnStrobeN, link.writeStrobeN}
                    <= reqPattern;
                link.bankSelect <= reqBank;
                link.address <= reqAddress;
            end else begin
                link.chipSelectN <= 1'b1;
                {link.rowStrobeN, link.columnStrobeN, link.writeStrobeN}
                    <= PAT_NOP;
            end
        end
    end
endmodule : ddr_controller_end
`default_nettype wire

/* bench/ddr_cmd_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module ddr_cmd_monitor
    import ddr_cmd_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic chipSelectN,
    input wire logic rowStrobeN,
    input wire logic columnStrobeN,
    input wire logic writeStrobeN,
    input wire logic clockGateInput,
    input wire logic [BANK_W-1:0] bankSelect,
    input wire logic [ADDR_W-1:0] address,
    input wire logic lowerLaneMask,
    input wire logic upperLaneMask,
    input wire logic [3:0] cmdCode,
    input wire logic [3:0] bankOpen,
    input wire logic [1:0] powerState,
    input wire logic [MODE_W-1:0] modeReg,
    input wire logic [MODE_W-1:0] extModeReg,
    input wire logic modeWritten,
    input wire logic [3:0] burstLength,
    input wire logic interleaved,
    input wire logic [3:0] readLatencyHalf,
    input wire logic burstActive,
    input wire logic burstIsWrite,
    input wire logic [COL_W-1:0] beatColumn,
    input wire logic [1:0] laneWriteEnable
);
    logic gatePrev_q;
    logic [2:0] pat, blCode, latCode;
    logic [1:0] masks;
    logic [3:0] latExp;
    logic live, modeCmd, closeAll, idleBanks, idleCmd, fall;

    always_ff @(posedge clock) begin
        gatePrev_q <= rst ? 1'b1 : clockGateInput;
    end
    assign pat = {rowStrobeN, columnStrobeN, writeStrobeN};
    assign masks = {upperLaneMask, lowerLaneMask};
    assign closeAll = address[AUTO_CLOSE_BIT];
    assign idleBanks = bankOpen == 4'h0;
    assign idleCmd = chipSelectN || pat == PAT_NOP;
    assign blCode = modeReg[BL_MSB:BL_LSB];
    assign latCode = modeReg[LAT_MSB:LAT_LSB];
    assign latExp = latCode == LAT_CODE_2 ? HALF_LAT_2 :
        latCode == LAT_CODE_3 ? HALF_LAT_3 :
        latCode == LAT_CODE_25 ? HALF_LAT_25 : 4'h0;
    assign live = !chipSelectN && powerState == 2'h0 && clockGateInput
        && gatePrev_q;
    assign modeCmd = live && pat == PAT_MODE && idleBanks && !burstActive;
    assign fall = powerState == 2'h0 && gatePrev_q && !clockGateInput;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence s_access;
        live && (pat == PAT_READ || pat == PAT_WRITE) && bankOpen[bankSelect];
    endsequence
    sequence s_access4;
        s_access ##0 burstLength == 4'h4;
    endsequence

    property p_modeLoad;
        modeCmd && !bankSelect[EXT_SEL_BIT]
            |=> modeReg == {$past(bankSelect), $past(address)};
    endproperty
    property p_extLoad;
        modeWritten && modeCmd && bankSelect[EXT_SEL_BIT]
            |=> extModeReg == {$past(bankSelect), $past(address)}
            && $stable(modeReg);
    endproperty
    property p_modeHold;
        modeWritten && !modeCmd |=> $stable(modeReg);
    endproperty
    property p_fields;
        modeWritten |-> interleaved == modeReg[ORDER_BIT]
            && burstLength == ((blCode != 3'h0 && blCode < 3'h4) ?
            4'h1 << blCode : 4'h0);
    endproperty
    property p_latency;
        modeWritten |-> readLatencyHalf == latExp;
    endproperty
    property p_open;
        live && pat == PAT_OPEN && !bankOpen[bankSelect]
            |=> bankOpen[$past(bankSelect)];
    endproperty
    property p_close;
        live && pat == PAT_CLOSE && !burstActive |=> bankOpen ==
            ($past(closeAll) ? 4'h0 : $past(bankOpen)
            & ~(4'h1 << $past(bankSelect)));
    endproperty
    property p_firstBeat;
        s_access |=> burstActive && beatColumn == $past(address[COL_W-1:0]);
    endproperty
    property p_burst4;
        s_access4 |=> burstActive [*4];
    endproperty
    property p_lane;
        burstActive && burstIsWrite |=> laneWriteEnable == ~$past(masks);
    endproperty
    property p_stop;
        live && pat == PAT_STOP && !burstActive |=> cmdCode == CMD_NOP;
    endproperty
    property p_selfEnter;
        fall && !chipSelectN && pat == PAT_REFRESH && idleBanks
            |=> powerState == 2'h1;
    endproperty
    property p_pdEnter;
        fall && idleCmd && !burstActive
            |=> powerState == ($past(idleBanks) ? 2'h2 : 2'h3);
    endproperty
    property p_wake;
        powerState != 2'h0 && !gatePrev_q && clockGateInput && idleCmd
            |=> powerState == 2'h0;
    endproperty

    a_modeLoad: assert property (p_modeLoad)
        else $error("mode register load wrong");
    a_extLoad: assert property (p_extLoad)
        else $error("extended register load wrong");
    a_modeHold: assert property (p_modeHold)
        else $error("mode register changed");
    a_fields: assert property (p_fields)
        else $error("length or order decode wrong");
    a_latency: assert property (p_latency)
        else $error("latency decode wrong");
    a_open: assert property (p_open)
        else $error("bank not opened");
    a_close: assert property (p_close)
        else $error("close result wrong");
    a_firstBeat: assert property (p_firstBeat)
        else $error("first beat column wrong");
    a_burst4: assert property (p_burst4)
        else $error("burst of four cut short");
    a_lane: assert property (p_lane)
        else $error("lane enables wrong");
    a_stop: assert property (p_stop)
        else $error("idle burst stop not ignored");
    a_selfEnter: assert property (p_selfEnter)
        else $error("self refresh not entered");
    a_pdEnter: assert property (p_pdEnter)
        else $error("power-down kind wrong");
    a_wake: assert property (p_wake)
        else $error("low power not left");
endmodule : ddr_cmd_monitor
`default_nettype wire

/* bench/ddr_sdram_command_and_mode_decode_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module ddr_sdram_command_and_mode_decode_tb_top
    import ddr_cmd_pkg::*;
;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic reqValid = 1'b0, reqChipSelectN = 1'b1, reqGate = 1'b1;
    logic [2:0] reqPattern = PAT_NOP;
    logic [BANK_W-1:0] reqBank = '0;
    logic [ADDR_W-1:0] reqAddress = '0;
    logic [1:0] reqMask = '0;
    logic reqReady, cmdValid, modeWritten, interleaved, testMode;
    logic burstActive, burstIsWrite, autoClose;
    logic [3:0] cmdCode, bankOpen, burstLength, readLatencyHalf;
    logic [1:0] powerState, laneWriteEnable, recoveryLeft;
    logic [MODE_W-1:0] modeReg, extModeReg;
    logic [COL_W-1:0] beatColumn;
    logic [3:0] expCmd[$];
    logic [15:0] expCol[$];
    int nErrors = 0, checkCount = 0;

    always #20 clock = ~clock;

    ddr_cmd_if link(.clock(clock));
    ddr_controller_end ddr_controller_end_i(.rst(rst), .link(link),
        .reqValid(reqValid), .reqPattern(reqPattern),
        .reqChipSelectN(reqChipSelectN), .reqGate(reqGate),
        .reqBank(reqBank), .reqAddress(reqAddress), .reqMask(reqMask),
        .reqReady(reqReady), .openBanks());
    ddr_memory_end ddr_memory_end_i(.rst(rst), .link(link),
        .cmdCode(cmdCode), .cmdValid(cmdValid), .bankOpen(bankOpen),
        .powerState(powerState), .modeReg(modeReg), .extModeReg(extModeReg),
        .modeWritten(modeWritten), .burstLength(burstLength),
        .interleaved(interleaved), .readLatencyHalf(readLatencyHalf),
        .testMode(testMode), .burstActive(burstActive),
        .burstIsWrite(burstIsWrite), .autoClose(autoClose),
        .beatColumn(beatColumn), .laneWriteEnable(laneWriteEnable),
        .recoveryLeft(recoveryLeft));
    ddr_cmd_monitor ddr_cmd_monitor_i(.clock(clock), .rst(rst),
        .chipSelectN(link.chipSelectN), .rowStrobeN(link.rowStrobeN),
        .columnStrobeN(link.columnStrobeN), .writeStrobeN(link.writeStrobeN),
        .clockGateInput(link.clockGateInput), .bankSelect(link.bankSelect),
        .address(link.address), .lowerLaneMask(link.lowerLaneMask),
        .upperLaneMask(link.upperLaneMask), .cmdCode(cmdCode),
        .bankOpen(bankOpen), .powerState(powerState), .modeReg(modeReg),
        .extModeReg(extModeReg), .modeWritten(modeWritten),
        .burstLength(burstLength), .interleaved(interleaved),
        .readLatencyHalf(readLatencyHalf), .burstActive(burstActive),
        .burstIsWrite(burstIsWrite), .beatColumn(beatColumn),
        .laneWriteEnable(laneWriteEnable));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checkCount++;
        if (seen !== exp) begin
            nErrors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic finishTest();
        if (nErrors == 0 && checkCount > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : finishTest

    task automatic send(input logic [2:0] pat, input logic cs,
        input logic gate, input logic [1:0] bank, input logic [12:0] addr);
        int n = 0;
        reqValid <= 1'b1;
        reqPattern <= pat;
        reqChipSelectN <= cs;
        reqGate <= gate;
        reqBank <= bank;
        reqAddress <= addr;
        reqMask <= 2'($urandom);
        @(negedge clock);
        while (reqReady !== 1'b1 && n < 8) begin
            @(negedge clock);
            n++;
        end
        check({15'h0, reqReady}, 16'h1);
        @(posedge clock);
    endtask : send

    task automatic idle(input int n);
        reqValid <= 1'b0;
        repeat (n) @(posedge clock);
    endtask : idle

    task automatic refuse(input logic [2:0] pat, input logic [1:0] bank);
        reqValid <= 1'b1;
        reqPattern <= pat;
        reqChipSelectN <= 1'b0;
        reqBank <= bank;
        @(negedge clock);
        check({15'h0, reqReady}, 16'h0);
        @(posedge clock);
        reqValid <= 1'b0;
        @(posedge clock);
    endtask : refuse

    always @(negedge clock) begin
        if (!rst && cmdValid) begin
            check({12'h0, cmdCode}, expCmd.size() ?
                {12'h0, expCmd.pop_front()} : 16'hffff);
        end
        if (!rst && burstActive) begin
            check({7'h0, beatColumn},
                expCol.size() ? expCol.pop_front() : 16'hffff);
        end
        if (!rst && cmdValid && cmdCode == CMD_MODE) begin
            check({14'h0, recoveryLeft}, 16'(MODE_RECOVERY_CYCLES));
        end
    end

    initial begin
        repeat (3000) @(posedge clock);
        nErrors++;
        finishTest();
    end

    initial begin
        logic [2:0] bl, lat;
        logic ord, wr, ac;
        logic [8:0] col;
        logic [1:0] b;
        logic [12:0] ea;
        int len;
        void'($urandom(32'h16ad81d8));
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        for (int k = 0; k < 6; k++) begin
            bl = 3'(k / 2 + 1);
            ord = k[0];
            wr = k[0] ^ k[1];
            ac = k == 5;
            lat = k < 2 ? LAT_CODE_2 : k < 4 ? LAT_CODE_3 : LAT_CODE_25;
            len = 1 << bl;
            expCmd.push_back(CMD_MODE);
            send(PAT_MODE, 1'b0, 1'b1, 2'h0, {6'h0, lat, ord, bl});
            refuse(PAT_OPEN, 2'h0);
            check({12'h0, burstLength}, 16'(len));
            check({15'h0, interleaved}, {15'h0, ord});
            check({12'h0, readLatencyHalf}, lat == LAT_CODE_2 ? 16'h4 :
                lat == LAT_CODE_3 ? 16'h6 : 16'h5);
            b = 2'($urandom);
            col = 9'($urandom);
            expCmd.push_back(CMD_OPEN);
            send(PAT_OPEN, 1'b0, 1'b1, b, 13'($urandom));
            for (int i = 0; i < (k == 4 ? 1 : len); i++) begin
                expCol.push_back(16'((col & ~9'(len - 1)) | ((ord ?
                    col ^ 9'(i) : col + 9'(i)) & 9'(len - 1))));
            end
            expCmd.push_back(wr ? CMD_WRITE : CMD_READ);
            send(wr ? PAT_WRITE : PAT_READ, 1'b0, 1'b1, b,
                {2'h0, ac, 1'b0, col});
            if (k == 4) begin
                expCmd.push_back(CMD_STOP);
                send(PAT_STOP, 1'b0, 1'b1, b, 13'h0);
            end
            idle(len + 3);
            check({14'h0, testMode, autoClose}, 16'(ac));
            if (ac) begin
                check({12'h0, bankOpen}, 16'h0);
            end else begin
                refuse(PAT_MODE, 2'h0);
                refuse(PAT_OPEN, b);
                expCmd.push_back(CMD_CLOSE);
                send(PAT_CLOSE, 1'b0, 1'b1, b, 13'h0);
                idle(2);
            end
        end
        expCmd.push_back(CMD_REFRESH);
        send(PAT_REFRESH, 1'b0, 1'b1, 2'h0, 13'h0);
        expCmd.push_back(CMD_SELF_ENTER);
        send(PAT_REFRESH, 1'b0, 1'b0, 2'h0, 13'h0);
        idle(4);
        expCmd.push_back(CMD_SELF_EXIT);
        send(PAT_NOP, 1'b1, 1'b1, 2'h0, 13'h0);
        idle(2);
        for (int k = 0; k < 2; k++) begin
            if (k == 1) begin
                expCmd.push_back(CMD_OPEN);
                send(PAT_OPEN, 1'b0, 1'b1, 2'h1, 13'h0);
            end
            expCmd.push_back(CMD_PD_ENTER);
            send(PAT_NOP, 1'b0, 1'b0, 2'h0, 13'h0);
            idle(2);
            check({14'h0, powerState}, k ? 16'h3 : 16'h2);
            expCmd.push_back(CMD_PD_EXIT);
            send(PAT_NOP, 1'b1, 1'b1, 2'h0, 13'h0);
            idle(2);
        end
        send(PAT_STOP, 1'b0, 1'b1, 2'h0, 13'h0);
        expCmd.push_back(CMD_CLOSE_ALL);
        send(PAT_CLOSE, 1'b0, 1'b1, 2'h2, 13'h400);
        idle(2);
        check({12'h0, bankOpen}, 16'h0);
        ea = 13'($urandom);
        expCmd.push_back(CMD_EXT_MODE);
        send(PAT_MODE, 1'b0, 1'b1, 2'h1, ea);
        idle(3);
        check({1'b0, modeReg}, 16'h006b);
        check({1'b0, extModeReg}, {3'h1, ea});
        check(16'(expCmd.size() + expCol.size()), 16'h0);
        finishTest();
    end
endmodule : ddr_sdram_command_and_mode_decode_tb_top
`default_nettype wire
